/* File: fault_resp.sv */
// Purpose: fault and trigger input response for a control pwm timer
// Assumes: ramp logic pulses phase_done_i when a phase ends and obeys hold/reload
// Notes: input A takes priority over input B for sequence changes
`timescale 1ns/1ps
`default_nettype none
`include "fault_resp_cfg.svh"

module fault_resp (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic event_a_i,
	input wire logic event_b_i,
	input wire fault_resp_pkg::wavegen_t wavegen_i,
	input wire logic phase_done_i,
	input wire logic raw_a_i,
	input wire logic raw_b_i,
	output logic wave_out_a_o,
	output logic wave_out_b_o,
	output fault_resp_pkg::phase_t phase_o,
	output logic count_hold_o,
	output logic count_reload_o,
	output logic [1:0] capture_event_o
);
	import fault_resp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register bus
	logic [4:0] ctrl [2];
	logic [31:0] prdata;
	wire setup_phase = psel_i & ~penable_i;
	wire wr_access = psel_i & penable_i & pwrite_i;
	wire hit_ctrl_a = paddr_i == `FR_OFS_CTRL_A;
	wire hit_ctrl_b = paddr_i == `FR_OFS_CTRL_B;
	wire hit_command = paddr_i == `FR_OFS_COMMAND;
	wire hit_status = paddr_i == `FR_OFS_STATUS;
	wire hit_any = hit_ctrl_a | hit_ctrl_b | hit_command | hit_status;
	wire restart_cmd = wr_access & hit_command & pwdata_i[`FR_RESTART_BIT];
	logic [31:0] status_word;
	logic [31:0] read_word;

	assign read_word = hit_ctrl_a ? {27'h0, ctrl[0]} :
		hit_ctrl_b ? {27'h0, ctrl[1]} :
		hit_status ? status_word : 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl[0] <= `FR_CTRL_RESET;
			ctrl[1] <= `FR_CTRL_RESET;
			prdata <= 32'h0;
		end else if (ce_i) begin
			if (wr_access & hit_ctrl_a) begin
				ctrl[0] <= pwdata_i[4:0];
			end
			if (wr_access & hit_ctrl_b) begin
				ctrl[1] <= pwdata_i[4:0];
			end
			if (setup_phase) begin
				prdata <= read_word;
			end
		end
	end

	assign prdata_o = prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit_any;

	////////////////////////////////////////////////////////////////////////////
	// per input decode
	phase_t phase;
	phase_t next_phase;
	logic halted;
	logic next_halted;
	logic w6;
	logic next_w6;
	logic [1:0] act;
	logic [1:0] next_act;
	logic [1:0] w2;
	logic [1:0] next_w2;
	logic [1:0] blank;
	logic [1:0] next_blank;
	logic [1:0] ev;
	logic [1:0] rise;
	logic [1:0] jump;
	logic [1:0] wait1;
	logic [1:0] m2;
	logic [1:0] m3;
	logic [1:0] g5;
	logic [1:0] g6;
	logic [1:0] g7;
	logic [1:0] all_off;
	logic [1:0] own_off;
	logic [1:0] bad;
	logic [1:0] blank_set;
	logic reload;
	wire [1:0] ev_pin = {event_b_i, event_a_i};
	wire on_time = phase[0];

	for (genvar i = 0; i < 2; i++) begin : g_in
		wire [3:0] m = ctrl[i][`FR_MODE_MSB:`FR_MODE_LSB];
		wire own = phase[1] == 1'(i);
		wire on_own = own & phase[0];
		wire opp_dead = phase == phase_t'({~1'(i), 1'b0});
		wire lvl_mode = m == RM_STOP_WAIT || m == RM_RUN_OPP_WAIT || m == RM_REPEAT_OPP;

		event_cond u_cond (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.event_i(ev_pin[i]),
			.enable_i(ctrl[i][`FR_ENABLE_BIT]),
			.level_o(ev[i]),
			.rise_o(rise[i])
		);

		assign jump[i] = (ev[i] & own & lvl_mode) |
			(rise[i] & on_own & m == RM_EDGE_JUMP);
		assign wait1[i] = act[i] & ev[i] & opp_dead & m == RM_STOP_WAIT;
		assign m2[i] = act[i] & ev[i] & m == RM_RUN_OPP_WAIT;
		assign m3[i] = act[i] & ev[i] & m == RM_REPEAT_OPP;
		assign g5[i] = ev[i] & m == RM_DEAD_ONLY;
		assign g6[i] = ev[i] & m == RM_DEAD_WAIT;
		assign g7[i] = ev[i] & m == RM_HALT_SW;
		assign all_off[i] = ev[i] & (m == RM_ALL_OFF || m == RM_DEAD_ONLY ||
			m == RM_DEAD_WAIT || m == RM_HALT_SW);
		assign own_off[i] = (ev[i] & (lvl_mode || m == RM_LEVEL_BLOCK)) | blank[i];
		assign blank_set[i] = on_own & ((rise[i] & m == RM_EDGE_BLOCK) |
			(ev[i] & m == RM_LEVEL_BLOCK));
		assign next_blank[i] = blank_set[i] | (blank[i] & on_own & next_phase == phase);
		assign bad[i] = (wavegen_i == WG_DUAL_SLOPE && m != RM_NONE && m != RM_ALL_OFF &&
			m != RM_HALT_SW) ||
			(wavegen_i == WG_ONE_RAMP && (m == RM_RUN_OPP_WAIT || m == RM_REPEAT_OPP ||
			m == RM_DEAD_ONLY || m == RM_DEAD_WAIT));
	end

	////////////////////////////////////////////////////////////////////////////
	// sequence control, modes 0, 4 and above eight fall through untouched
	wire any5 = |g5;
	wire any6 = |g6;
	wire halt_trig = |g7;
	wire hold = halted | w6 | (|w2) | (|wait1);
	wire [1:0] jump_src = jump[0] ? 2'h0 : 2'h1;
	phase_t opp_dead_of_src;
	phase_t other_dead;

	assign opp_dead_of_src = phase_t'({~jump_src[0], 1'b0});
	assign other_dead = phase_t'({~phase[1], 1'b0});

	always_comb begin
		next_phase = phase;
		next_halted = halt_trig | (halted & ~restart_cmd);
		next_w6 = w6;
		next_w2 = w2;
		next_act = act;
		reload = 1'b0;
		if (restart_cmd) begin
			next_phase = DEAD_A;
			next_w6 = 1'b0;
			next_w2 = 2'h0;
			next_act = 2'h0;
			reload = 1'b1;
		end else if (halt_trig | halted) begin
			next_phase = phase;
		end else if (w6) begin
			if (!any6) begin
				next_w6 = 1'b0;
				next_phase = other_dead;
				reload = 1'b1;
			end
		end else if (|w2) begin
			if (w2[0] & ~ev[0]) begin
				next_w2[0] = 1'b0;
				next_phase = DEAD_A;
				reload = 1'b1;
			end else if (w2[1] & ~ev[1]) begin
				next_w2[1] = 1'b0;
				next_phase = DEAD_B;
				reload = 1'b1;
			end
		end else if (|jump) begin
			next_phase = opp_dead_of_src;
			next_act[jump_src[0]] = ctrl[jump_src[0]][`FR_MODE_MSB:`FR_MODE_LSB] != RM_EDGE_JUMP;
			reload = 1'b1;
		end else if ((any5 | any6) & on_time) begin
			next_phase = other_dead;
			reload = 1'b1;
		end else if (phase_done_i & ~(|wait1)) begin
			next_phase = phase_t'(phase + 2'h1);
			if (!on_time && any5) begin
				next_phase = other_dead;
				reload = 1'b1;
			end else if (!on_time && any6) begin
				next_phase = phase;
				next_w6 = 1'b1;
			end else if (phase == ON_B && m2[0]) begin
				next_phase = phase;
				next_w2[0] = 1'b1;
			end else if (phase == ON_A && m2[1]) begin
				next_phase = phase;
				next_w2[1] = 1'b1;
			end else if (phase == ON_B && m3[0]) begin
				next_phase = DEAD_B;
				reload = 1'b1;
			end else if (phase == ON_A && m3[1]) begin
				next_phase = DEAD_A;
				reload = 1'b1;
			end
			if (next_phase == DEAD_A) begin
				next_act[0] = 1'b0;
			end
			if (next_phase == DEAD_B) begin
				next_act[1] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= DEAD_A;
			halted <= 1'b0;
			w6 <= 1'b0;
			w2 <= 2'h0;
			act <= 2'h0;
			blank <= 2'h0;
		end else if (ce_i) begin
			phase <= next_phase;
			halted <= next_halted;
			w6 <= next_w6;
			w2 <= next_w2;
			act <= next_act;
			blank <= next_blank;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output override, registered after the two sync stages
	wire force_all = (|all_off) | halted;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wave_out_a_o <= 1'b0;
			wave_out_b_o <= 1'b0;
			count_reload_o <= 1'b0;
			capture_event_o <= 2'h0;
		end else if (ce_i) begin
			wave_out_a_o <= raw_a_i & ~force_all & ~own_off[0];
			wave_out_b_o <= raw_b_i & ~force_all & ~own_off[1];
			count_reload_o <= reload;
			capture_event_o <= rise;
		end
	end

	assign phase_o = phase;
	assign count_hold_o = hold;
	assign status_word = {24'h0, ev[1], ev[0], bad[1], bad[0], hold, halted, phase};
endmodule
`default_nettype wire

/* File: fault_resp_cfg.svh */
// Purpose: offsets, field positions, reset values and timing for the fault response block
// Assumes: APB word registers, byte addresses
// Notes: definitions only
`ifndef FAULT_RESP_CFG_SVH
`define FAULT_RESP_CFG_SVH

`define FR_OFS_CTRL_A 12'h000
`define FR_OFS_CTRL_B 12'h004
`define FR_OFS_COMMAND 12'h008
`define FR_OFS_STATUS 12'h00C

`define FR_MODE_LSB 0
`define FR_MODE_MSB 3
`define FR_ENABLE_BIT 4
`define FR_RESTART_BIT 0

`define FR_CTRL_RESET 5'h00

`define FR_ST_PHASE_LSB 0
`define FR_ST_HALTED_BIT 2
`define FR_ST_HOLD_BIT 3
`define FR_ST_BAD_A_BIT 4
`define FR_ST_BAD_B_BIT 5
`define FR_ST_EV_A_BIT 6
`define FR_ST_EV_B_BIT 7

`define FR_SYNC_STAGES 2

`endif

/* File: fault_resp_pkg.sv */
// Purpose: types shared by the fault response block
// Assumes: nothing
// Notes: phase codes increment in normal order
package fault_resp_pkg;

	typedef enum logic [1:0] {
		DEAD_A = 2'h0,
		ON_A = 2'h1,
		DEAD_B = 2'h2,
		ON_B = 2'h3
	} phase_t;

	typedef enum logic [1:0] {
		WG_ONE_RAMP = 2'h0,
		WG_TWO_RAMP = 2'h1,
		WG_FOUR_RAMP = 2'h2,
		WG_DUAL_SLOPE = 2'h3
	} wavegen_t;

	typedef enum logic [3:0] {
		RM_NONE = 4'h0,
		RM_STOP_WAIT = 4'h1,
		RM_RUN_OPP_WAIT = 4'h2,
		RM_REPEAT_OPP = 4'h3,
		RM_ALL_OFF = 4'h4,
		RM_DEAD_ONLY = 4'h5,
		RM_DEAD_WAIT = 4'h6,
		RM_HALT_SW = 4'h7,
		RM_EDGE_JUMP = 4'h8,
		RM_EDGE_BLOCK = 4'h9,
		RM_LEVEL_BLOCK = 4'hA
	} resp_mode_t;

endpackage

/* File: event_cond.sv */
// Purpose: synchronise one event input, gate it with its enable, find rising edges
// Assumes: event may change at any edge
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
`include "fault_resp_cfg.svh"

module event_cond (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic event_i,
	input wire logic enable_i,
	output logic level_o,
	output logic rise_o
);
	logic [`FR_SYNC_STAGES-1:0] sync;
	logic prev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync <= '0;
			prev <= 1'b0;
		end else if (ce_i) begin
			sync <= {sync[`FR_SYNC_STAGES-2:0], event_i};
			prev <= sync[`FR_SYNC_STAGES-1];
		end
	end

	assign level_o = sync[`FR_SYNC_STAGES-1] & enable_i;
	assign rise_o = sync[`FR_SYNC_STAGES-1] & ~prev & enable_i;
endmodule
`default_nettype wire

/* File: fault_resp_props.sv */
// Purpose: port assertions for fault_resp
// Assumes: one clock, sync reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fault_resp_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic event_a_i,
	input wire logic raw_a_i,
	input wire logic raw_b_i,
	input wire logic wave_out_a_o,
	input wire logic wave_out_b_o,
	input wire fault_resp_pkg::phase_t phase_o,
	input wire logic count_reload_o,
	input wire logic [1:0] capture_event_o
);
	import fault_resp_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence access_s;
		psel_i && penable_i;
	endsequence
	sequence step_s;
		$changed(phase_o) && !count_reload_o;
	endsequence
	ready_high_a: assert property (access_s |-> pready_o)
		else $error("ready low");
	unmapped_err_a: assert property (access_s ##0 paddr_i > 12'h00C |-> pslverr_o)
		else $error("no slave error");
	mapped_ok_a: assert property (access_s ##0 (paddr_i <= 12'h00C && paddr_i[1:0] == 2'h0)
		|-> !pslverr_o) else $error("false slave error");
	force_low_a_a: assert property (wave_out_a_o |-> $past(raw_a_i))
		else $error("output a raised");
	force_low_b_a: assert property (wave_out_b_o |-> $past(raw_b_i))
		else $error("output b raised");
	phase_order_a: assert property (step_s |-> phase_o == phase_t'($past(phase_o) + 2'h1))
		else $error("phase skipped");
	reset_phase_a: assert property ($fell(rst_i) |-> phase_o == DEAD_A && !wave_out_a_o)
		else $error("reset phase wrong");
	capture_cause_a: assert property (capture_event_o[0] |-> $past(event_a_i, 2))
		else $error("capture without event");
endmodule
bind fault_resp fault_resp_props props (.clk_i, .rst_i, .paddr_i, .psel_i, .penable_i,
	.pready_o, .pslverr_o, .event_a_i, .raw_a_i, .raw_b_i, .wave_out_a_o, .wave_out_b_o,
	.phase_o, .count_reload_o, .capture_event_o);
`default_nettype wire

/* File: event_net.sv */
// Purpose: event routing stand-in driving the two fault inputs
// Assumes: events are synchronous levels
// Notes: one pulse of len_i cycles per fire_i
`timescale 1ns/1ps
`default_nettype none
module event_net (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fire_i,
	input wire logic sel_b_i,
	input wire logic [7:0] len_i,
	output logic event_a_o,
	output logic event_b_o
);
	logic [7:0] left;
	logic on_b;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			left <= 8'h00;
		else if (fire_i)
			left <= len_i;
		else if (left != 8'h00)
			left <= left - 8'h01;
		if (fire_i)
			on_b <= sel_b_i;
	end
	assign event_a_o = left != 8'h00 && !on_b;
	assign event_b_o = left != 8'h00 && on_b;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for fault_resp
// Assumes: 50 MHz clock, sync reset
// Notes: ramp stand-in gives four-cycle phases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fault_resp_pkg::*;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, e;
	logic ev_a, ev_b, done = 1'h0, raw_a = 1'h0, raw_b = 1'h0, wa, wb, hold, reload;
	logic fire = 1'h0, sel_b = 1'h0, ce = 1'h1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [7:0] len = 8'h00;
	logic [1:0] cnt = 2'h0, cap;
	wavegen_t wg = WG_TWO_RAMP;
	phase_t ph;
	int errors = 0, tests_run = 0, fa, hi, nh, caps, moves;
	fault_resp dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .event_a_i(ev_a), .event_b_i(ev_b),
		.wavegen_i(wg), .phase_done_i(done), .raw_a_i(raw_a), .raw_b_i(raw_b),
		.wave_out_a_o(wa), .wave_out_b_o(wb), .phase_o(ph), .count_hold_o(hold),
		.count_reload_o(reload), .capture_event_o(cap));
	event_net net (.clk_i(clk), .rst_i(rst), .fire_i(fire), .sel_b_i(sel_b), .len_i(len),
		.event_a_o(ev_a), .event_b_o(ev_b));
	initial begin
		forever #10 clk = ~clk;
	end
	// ramp stand-in
	always_ff @(posedge clk) begin
		cnt <= (rst || reload) ? 2'h0 : cnt + {1'h0, !hold};
		done <= cnt == 2'h2 && !hold;
		raw_a <= ph == ON_A;
		raw_b <= ph == ON_B;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("tests %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (n > 50) begin
				errors++;
				results();
			end
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic go(input logic [7:0] l);
		len <= l;
		fire <= 1'h1;
		@(posedge clk);
		fire <= 1'h0;
	endtask
	task automatic watch(input int n);
		logic ra;
		phase_t p;
		ra = 1'h0;
		p = ph;
		{fa, hi, nh, caps, moves} = '0;
		repeat (n) begin
			@(negedge clk);
			fa += int'(ra && !wa);
			hi += int'(wa || wb);
			nh += int'(hold);
			caps += int'(cap[0]);
			moves += int'(ph != p);
			ra = raw_a;
			p = ph;
			@(posedge clk);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(1'h0, 12'h000, 32'h0);
		chk(q, 32'h0);
		apb(1'h1, 12'h000, 32'h1A);
		apb(1'h1, 12'h004, 32'h12);
		apb(1'h0, 12'h004, 32'h0);
		chk(q, 32'h12);
		wg <= WG_DUAL_SLOPE;
		apb(1'h0, 12'h00C, 32'h0);
		chk(q & 32'h30, 32'h30);
		wg <= WG_ONE_RAMP;
		apb(1'h0, 12'h00C, 32'h0);
		chk(q & 32'h30, 32'h20);
		wg <= WG_TWO_RAMP;
		apb(1'h0, 12'h010, 32'h0);
		chk({q[31:1], e}, 32'h1);
		$display("registers done");
	endtask
	task automatic t_mode0();
		apb(1'h1, 12'h000, 32'h10);
		go(8'h0C);
		watch(24);
		chk(32'(fa), 32'h0);
		chk(32'(nh), 32'h0);
		chk(32'(caps), 32'h1);
		$display("mode 0 done");
	endtask
	task automatic t_mode4();
		apb(1'h1, 12'h000, 32'h04);
		go(8'h14);
		watch(24);
		chk(32'(fa), 32'h0);
		apb(1'h1, 12'h000, 32'h14);
		go(8'h18);
		watch(4);
		watch(16);
		chk(32'(hi), 32'h0);
		chk(32'(nh), 32'h0);
		chk(32'(moves), 32'h4);
		watch(28);
		chk(32'(hi > 0), 32'h1);
		$display("mode 4 done");
	endtask
	task automatic t_mode7();
		apb(1'h1, 12'h000, 32'h17);
		go(8'h1E);
		watch(10);
		apb(1'h0, 12'h00C, 32'h0);
		chk(q & 32'h4, 32'h4);
		apb(1'h1, 12'h008, 32'h1);
		watch(6);
		apb(1'h0, 12'h00C, 32'h0);
		chk(q & 32'h4, 32'h4);
		watch(20);
		chk(32'(hi), 32'h0);
		apb(1'h1, 12'h008, 32'h1);
		apb(1'h0, 12'h00C, 32'h0);
		chk(q & 32'h7, 32'h0);
		$display("mode 7 done");
	endtask
	task automatic t_ce();
		phase_t p;
		ce <= 1'h0;
		@(posedge clk);
		p = ph;
		apb(1'h1, 12'h000, 32'h15);
		repeat (8) @(posedge clk);
		chk(32'(ph), 32'(p));
		ce <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk(q, 32'h17);
		$display("clock enable done");
	endtask
	task automatic t_mode8();
		int n;
		apb(1'h1, 12'h000, 32'h18);
		n = 0;
		while (ph == DEAD_A && n < 40) begin
			@(negedge clk);
			n++;
		end
		while (ph != DEAD_A && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) begin
			errors++;
			results();
		end
		@(posedge clk);
		go(8'h02);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(32'(ph), 32'(DEAD_B));
		chk(32'(reload), 32'h1);
		$display("mode 8 done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_regs();
		t_mode0();
		t_mode4();
		t_mode7();
		t_ce();
		t_mode8();
		results();
	end
endmodule
`default_nettype wire
